// file: sssrc_map.vh
// Constants of the supply supervisor and reset control block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SSSRC_MAP_VH
`define SSSRC_MAP_VH
`define SSSRC_ADDR_CTRL 4'h0
`define SSSRC_ADDR_STAT 4'h4
`define SSSRC_ADDR_IRQ 4'h8
`define SSSRC_ADDR_MASK 4'hC
`define SSSRC_ADDR_OPT 4'h0
`define SSSRC_CTRL_DET_EN 0
`define SSSRC_CTRL_DET_LVL 1
`define SSSRC_CTRL_DET_LVL_W 3
`define SSSRC_CTRL_REG_MODE 4
`define SSSRC_CTRL_REG_MODE_W 2
`define SSSRC_IRQ_FALL 0
`define SSSRC_IRQ_RISE 1
`define SSSRC_MODE_MAIN 2'h0
`define SSSRC_MODE_LOWP 2'h1
`define SSSRC_MODE_PDOWN 2'h2
`define SSSRC_BOR_OFF 2'h0
`define SSSRC_BOR_LVL1 2'h1
`define SSSRC_BOR_LVL2 2'h2
`define SSSRC_BOR_LVL3 2'h3
`define SSSRC_LOAD_TIME_NS 200
`define SSSRC_CLK_NS 10
`define SSSRC_LOAD_CYCLES ((`SSSRC_LOAD_TIME_NS + `SSSRC_CLK_NS - 1) / `SSSRC_CLK_NS)
`define SSSRC_SYNC_CYCLES 4
`endif

// file: sssrc_top.v
// Supply supervisor and reset control: power-on/down reset, brownout reset,
// option byte loading, voltage detector interrupt, straps and regulator mode.
// Assumes supply comparators arrive as clean inputs synchronous to clk_i.
// Operation
// - Supervisor enabled by strap high, or always.
// - Power-on reset held active through every power-up while internal reset is on.
// - Load option bytes after power-on threshold passes.
// - Three brownout thresholds chosen by option bytes.
// - Hold reset while supply below active threshold.
// - Detector interrupts on falling, rising or both.
// - Strap low disables internal power reset circuitry.
// - Detector forced off when internal reset off.
// - Backup supply dropped when internal reset off.
// - Regulator offers main, low-power and power-down.
// - Regulator enabled by bypass strap low, or always.
`timescale 1ns/1ps
`include "sssrc_map.vh"

module sssrc_top #(
  parameter HAS_SUPERVISOR_PIN = 1,
  parameter HAS_BYPASS_PIN = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  input wire supervisor_enable_strap_i,
  input wire bypass_strap_i,
  input wire above_por_i,
  input wire [2:0] above_bor_i,
  input wire above_detector_threshold_i,
  input wire reset_pin_n_i,
  input wire [1:0] opt_bor_level_i,
  input wire opt_valid_i,
  output reg opt_load_req_o,
  output reg sys_rst_o,
  output reg irq_o,
  output reg detector_active_o,
  output reg [2:0] detector_level_o,
  output reg backup_supply_en_o,
  output reg regulator_en_o,
  output reg [1:0] regulator_mode_o
);

  // Option load sequencing states.
  localparam [1:0] LOAD_WAIT = 2'b00;
  localparam [1:0] LOAD_BUSY = 2'b01;
  localparam [1:0] LOAD_DONE = 2'b10;
  // Load and release counts, cut to the width of the counters they meet.
  localparam integer LOAD_MIN_INT = `SSSRC_LOAD_CYCLES;
  localparam [7:0] LOAD_MIN = LOAD_MIN_INT[7:0];
  localparam [7:0] LOAD_CAP = 8'hFF;
  localparam integer REL_MAX_INT = `SSSRC_SYNC_CYCLES;
  localparam [3:0] REL_MAX = REL_MAX_INT[3:0];

  reg internal_on;
  reg [2:0] det_lvl;
  reg det_en;
  reg [1:0] mode_sel;
  reg [1:0] next_mode;
  reg [1:0] irq_stat;
  reg [1:0] next_irq_stat;
  reg [1:0] irq_mask;
  reg [1:0] bor_level;
  reg [1:0] load_state;
  reg [1:0] next_load_state;
  reg opt_loaded;
  reg [7:0] load_cnt;
  reg det_prev;
  reg det_prev_ok;
  reg [3:0] rel_cnt;
  reg bor_above;
  wire supervisor_on;
  wire power_low;
  wire bor_low;
  wire reset_req;
  wire det_live;
  wire bus_req;
  wire bus_wr;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_irq;
  wire [1:0] mode_req;
  wire [1:0] det_evt;
  reg [31:0] next_dat;

  // Straps: without the pin the supervisor and regulator are always on.
  assign supervisor_on = (HAS_SUPERVISOR_PIN == 0) | supervisor_enable_strap_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      internal_on <= 1'b1;
    end else begin
      internal_on <= supervisor_on;
    end
  end

  // Brownout comparator picked by loaded option level; level zero means off.
  // An explicit case keeps the off level from indexing a comparator at all.
  always @* begin
    bor_above = 1'b1;
    case (bor_level)
      `SSSRC_BOR_OFF: bor_above = 1'b1;
      `SSSRC_BOR_LVL1: bor_above = above_bor_i[0];
      `SSSRC_BOR_LVL2: bor_above = above_bor_i[1];
      `SSSRC_BOR_LVL3: bor_above = above_bor_i[2];
      default: bor_above = 1'b1;
    endcase
  end

  // Strap low also silences brownout, so a stale option level cannot reset
  // a board whose external supervisor already owns the reset pin.
  assign bor_low = opt_loaded && internal_on && !bor_above;

  // Power-on/power-down comparator counts only while internal reset is on.
  assign power_low = internal_on && !above_por_i;

  // Any request holds reset: power threshold, brownout, pin, or unloaded options.
  assign reset_req = power_low || bor_low || !reset_pin_n_i ||
                     !opt_loaded;

  // Option load sequence: wait for power, count the minimum load time, then
  // take the option content. A power loss while internal reset is on sends it back
  // to the start, so such a dip always ends in a fresh load rather than stale thresholds.
  always @* begin
    next_load_state = load_state;
    case (load_state)
      LOAD_WAIT: begin
        if (!power_low) begin
          next_load_state = LOAD_BUSY;
        end
      end
      LOAD_BUSY: begin
        if (power_low) begin
          next_load_state = LOAD_WAIT;
        end else if (opt_valid_i && load_cnt >= LOAD_MIN) begin
          next_load_state = LOAD_DONE;
        end
      end
      LOAD_DONE: begin
        if (power_low) begin
          next_load_state = LOAD_WAIT;
        end
      end
      default: next_load_state = LOAD_WAIT;
    endcase
  end

  // Option load registers; the level is captured only on the finishing edge.
  always @(posedge clk_i) begin
    if (rst_i) begin
      load_state <= LOAD_WAIT;
      load_cnt <= 8'h00;
      opt_load_req_o <= 1'b0;
      opt_loaded <= 1'b0;
      bor_level <= `SSSRC_BOR_OFF;
    end else begin
      load_state <= next_load_state;
      opt_load_req_o <= (next_load_state == LOAD_BUSY);
      opt_loaded <= (next_load_state == LOAD_DONE);
      // The counter saturates so a late option source cannot wrap it.
      if (next_load_state != LOAD_BUSY) begin
        load_cnt <= 8'h00;
      end else if (load_cnt != LOAD_CAP) begin
        load_cnt <= load_cnt + 8'h01;
      end
      if (load_state == LOAD_BUSY && next_load_state == LOAD_DONE) begin
        bor_level <= opt_bor_level_i;
      end
    end
  end

  // Release waits a few clean cycles so reset deasserts on a clock edge.
  // Any request during the count starts it over, which filters short glitches.
  always @(posedge clk_i) begin
    if (rst_i || reset_req) begin
      sys_rst_o <= 1'b1;
      rel_cnt <= 4'h0;
    end else if (rel_cnt != REL_MAX) begin
      rel_cnt <= rel_cnt + 4'h1;
    end else begin
      sys_rst_o <= 1'b0;
    end
  end

  // Detector runs only when software enabled it and internal reset is on.
  assign det_live = det_en && internal_on;
  assign det_evt[`SSSRC_IRQ_FALL] = det_live && det_prev_ok && det_prev &&
                                    !above_detector_threshold_i;
  assign det_evt[`SSSRC_IRQ_RISE] = det_live && det_prev_ok && !det_prev &&
                                    above_detector_threshold_i;

  // Bus decode. A request is taken when it first appears, but a write only
  // lands at the edge where the master sees ack, with everything still held.
  // A status read clears at the request edge, together with the data capture.
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = cyc_i && stb_i && we_i && ack_o;
  assign wr_ctrl = bus_wr && (adr_i == `SSSRC_ADDR_CTRL) && sel_i[0];
  assign wr_mask = bus_wr && (adr_i == `SSSRC_ADDR_MASK) && sel_i[0];
  assign rd_irq = bus_req && !we_i && (adr_i == `SSSRC_ADDR_IRQ);
  assign mode_req = dat_i[`SSSRC_CTRL_REG_MODE +: `SSSRC_CTRL_REG_MODE_W];

  // Regulator mode request; the unused code leaves the mode as it was.
  always @* begin
    case (mode_req)
      `SSSRC_MODE_MAIN: next_mode = `SSSRC_MODE_MAIN;
      `SSSRC_MODE_LOWP: next_mode = `SSSRC_MODE_LOWP;
      `SSSRC_MODE_PDOWN: next_mode = `SSSRC_MODE_PDOWN;
      default: next_mode = mode_sel;
    endcase
  end

  // Control register: detector enable and level, regulator mode.
  always @(posedge clk_i) begin
    if (rst_i) begin
      det_en <= 1'b0;
      det_lvl <= 3'h0;
      mode_sel <= `SSSRC_MODE_MAIN;
    end else if (wr_ctrl) begin
      det_en <= dat_i[`SSSRC_CTRL_DET_EN];
      det_lvl <= dat_i[`SSSRC_CTRL_DET_LVL +: `SSSRC_CTRL_DET_LVL_W];
      mode_sel <= next_mode;
    end
  end

  // Mask register, same layout as the status register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= 2'b00;
    end else if (wr_mask) begin
      irq_mask <= dat_i[1:0];
    end
  end

  // Comparator history; the valid flag stops a false edge right after enable.
  always @(posedge clk_i) begin
    if (rst_i) begin
      det_prev <= 1'b0;
      det_prev_ok <= 1'b0;
    end else begin
      det_prev <= above_detector_threshold_i;
      det_prev_ok <= det_live;
    end
  end

  // Status bits: a read clears them, but an event in the same cycle wins.
  always @* begin
    if (rd_irq) begin
      next_irq_stat = det_evt;
    end else begin
      next_irq_stat = irq_stat | det_evt;
    end
  end

  // Status register update.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'b00;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Bus answer one cycle after request; unmapped reads return zero.
  always @* begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      `SSSRC_ADDR_CTRL: next_dat = {26'h0, mode_sel, det_lvl, det_en};
      `SSSRC_ADDR_STAT: next_dat = {24'h0, bor_level, opt_loaded, regulator_en_o,
                                    internal_on, above_detector_threshold_i,
                                    det_live, sys_rst_o};
      `SSSRC_ADDR_IRQ: next_dat = {30'h0, irq_stat};
      `SSSRC_ADDR_MASK: next_dat = {30'h0, irq_mask};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  // Registered outputs.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      detector_active_o <= 1'b0;
      detector_level_o <= 3'h0;
      backup_supply_en_o <= 1'b0;
      regulator_en_o <= 1'b1;
      regulator_mode_o <= `SSSRC_MODE_MAIN;
    end else begin
      ack_o <= bus_req;
      dat_o <= (bus_req && !we_i) ? next_dat : 32'h0000_0000;
      irq_o <= |(irq_stat & irq_mask) && internal_on;
      detector_active_o <= det_live;
      detector_level_o <= det_lvl;
      backup_supply_en_o <= internal_on;
      regulator_en_o <= (HAS_BYPASS_PIN == 0) | !bypass_strap_i;
      regulator_mode_o <= mode_sel;
    end
  end

endmodule // sssrc_top

// file: sssrc_props.sv
// Checker of the supply supervisor: bus handshake and merged reset.
// Assumes a bind onto sssrc_top, seeing its ports by name.
`timescale 1ns/1ps
module sssrc_props (
  input wire clk_i, rst_i, cyc_i, stb_i, ack_o, reset_pin_n_i,
  input wire supervisor_enable_strap_i, above_por_i, sys_rst_o, opt_load_req_o,
  input wire detector_active_o, backup_supply_en_o, bypass_strap_i, regulator_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A freed pin keeps the reset up while its release is resynchronised.
  sequence pin_freed; !reset_pin_n_i ##1 reset_pin_n_i; endsequence
  sequence bus_req; cyc_i && stb_i && !ack_o; endsequence
  a_ack_answer: assert property (bus_req |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
  a_pin_hold: assert property (!reset_pin_n_i |=> sys_rst_o) else $error("pin");
  a_pin_release: assert property (pin_freed |-> sys_rst_o [*4]) else $error("early");
  a_por_hold: assert property (supervisor_enable_strap_i && $past(supervisor_enable_strap_i)
    && !above_por_i |=> sys_rst_o) else $error("por");
  a_load_in_reset: assert property (opt_load_req_o |-> sys_rst_o) else $error("load");
  a_strap_off: assert property (!supervisor_enable_strap_i [*3] |->
    !detector_active_o && !backup_supply_en_o) else $error("strap");
  a_regulator_on: assert property (!bypass_strap_i [*3] |-> regulator_en_o)
    else $error("regulator");
endmodule // sssrc_props
bind sssrc_top sssrc_props u_sssrc_props (.*);

// file: sssrc_ext_sup.sv
// External supply supervisor model driving the active-low reset pin.
// Assumes the bench says when the supply is below its trip level.
`timescale 1ns/1ps
module sssrc_ext_sup #(
  parameter HOLD = 3
) (
  input wire clk_i,
  input wire below_i,
  output logic reset_pin_n_o = 1'h0
);
  int cnt = 0;
  // Holding the pin past recovery mimics a slow supervisor.
  always @(posedge clk_i) begin
    cnt <= below_i ? HOLD : (cnt > 0 ? cnt - 1 : 0);
    reset_pin_n_o <= !below_i && cnt == 0;
  end
endmodule // sssrc_ext_sup

// file: test_supply_supervisor_reset_control.sv
// Bench of the supply supervisor: bus cycles, supply moves, read scoreboard.
// Assumes sssrc_top with its bound checker and the model sssrc_ext_sup.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_supply_supervisor_reset_control;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, low = 1, above_por_i = 0;
  logic supervisor_enable_strap_i = 1, bypass_strap_i = 0, above_detector_threshold_i = 1;
  logic opt_valid_i = 0, ack_o, opt_load_req_o, sys_rst_o, irq_o, detector_active_o;
  logic backup_supply_en_o, regulator_en_o, reset_pin_n_i;
  logic [3:0] adr_i = 0, sel_i = 4'hf;
  logic [31:0] dat_i = 0, dat_o, c, exp_q[$];
  logic [2:0] above_bor_i = 0, detector_level_o;
  logic [1:0] opt_bor_level_i = 0, regulator_mode_o, lvl;
  int n_fail = 0, checks_done = 0, seed = 83814, m;
  sssrc_top u_sssrc_top (.*);
  sssrc_ext_sup u_sssrc_ext_sup (.clk_i(clk_i), .below_i(low), .reset_pin_n_o(reset_pin_n_i));
  // Clock of 10 ns period.
  always #5 clk_i = ~clk_i;
  // Read data is judged at the edge where the master sees ack.
  always @(posedge clk_i) if (ack_o === 1'b1 && !we_i) `CHK(dat_o, exp_q.pop_front())
  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One classic cycle held until ack; a read first notes its expected word.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, w ? d : 32'h0};
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin n_fail++; conclude; end
    {cyc_i, stb_i} <= 2'h0;
  endtask
  // Bounded wait for the merged reset to let go.
  task automatic settle;
    int n = 0;
    while (sys_rst_o !== 1'b0 && n < 99) begin @(posedge clk_i); n++; end
    if (n >= 99) begin n_fail++; conclude; end
  endtask
  // Power up, registers, detector events, brownout and straps.
  initial begin
    lvl = 2'h1 + 2'({$random(seed)} % 3);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    {low, above_por_i, above_bor_i, opt_valid_i, opt_bor_level_i} <= {2'h1, 3'h7, 1'h1, lvl};
    settle;
    `CHK(opt_load_req_o, 1'b0)
    for (m = 0; m < 4; m++) begin
      c = {26'h0, m[1:0], 3'($random(seed)), 1'h1};
      wb(1, 4'h0, c);
      repeat (2) @(posedge clk_i);
      `CHK({detector_active_o, regulator_mode_o}, {1'h1, m < 3 ? m[1:0] : 2'h2})
      `CHK(detector_level_o, c[3:1])
      if (m < 3) wb(0, 4'h0, c);
    end
    wb(0, 4'h2, 32'h0);
    wb(1, 4'hc, 32'h3);
    for (m = 0; m < 3; m++) begin
      if (m == 2) wb(1, 4'hc, 32'h0);
      above_detector_threshold_i <= m[0];
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, m < 2)
      wb(0, 4'h8, m == 1 ? 32'h2 : 32'h1);
    end
    above_bor_i <= 3'h7 >> (3'h3 - lvl);
    repeat (3) @(posedge clk_i);
    `CHK(sys_rst_o, 1'b0)
    above_bor_i <= 3'h7 >> (3'h4 - lvl);
    repeat (3) @(posedge clk_i);
    `CHK(sys_rst_o, 1'b1)
    above_bor_i <= 3'h7;
    settle;
    wb(1, 4'hc, 32'h3);
    {supervisor_enable_strap_i, opt_bor_level_i, low} <= 4'h1;
    above_detector_threshold_i <= 1;
    repeat (4) @(posedge clk_i);
    `CHK({sys_rst_o, detector_active_o, backup_supply_en_o, irq_o}, 4'h8)
    low <= 0;
    settle;
    {above_por_i, bypass_strap_i} <= 2'h1;
    repeat (3) @(posedge clk_i);
    `CHK({sys_rst_o, regulator_en_o}, 2'h0)
    conclude;
  end
endmodule // test_supply_supervisor_reset_control
